// >>> rtl/pcib_regs.svh
/*
 * constants of the pci port: bus commands, decode windows, wait counts.
 * assumes inclusion by the package and by both ends of the link.
 */
`ifndef PCIB_REGS_SVH
`define PCIB_REGS_SVH

// ----------------------------------------------------------------------
// bus commands
// ----------------------------------------------------------------------
`define PCIB_CMD_IO_RD    4'h2
`define PCIB_CMD_IO_WR    4'h3
`define PCIB_CMD_MEM_RD   4'h6
`define PCIB_CMD_MEM_WR   4'h7
`define PCIB_CMD_CFG_RD   4'hA
`define PCIB_CMD_CFG_WR   4'hB

// ----------------------------------------------------------------------
// positive decode windows (i/o space)
// ----------------------------------------------------------------------
`define PCIB_INT_BASE     32'h00000000
`define PCIB_INT_MASK     32'hFFFFFF00
`define PCIB_IDE_BASE     32'h000001F0
`define PCIB_IDE_MASK     32'hFFFFFFF8
`define PCIB_XIO_BASE     32'h00000300
`define PCIB_XIO_MASK     32'hFFFFFFF0

// ----------------------------------------------------------------------
// timing counts in pci clocks
// ----------------------------------------------------------------------
`define PCIB_SUB_WAIT     3'h2
`define PCIB_ABORT_CLKS   3'h5
`define PCIB_CNT_RST      3'h0

`endif

// >>> rtl/pcib_pkg.sv
/*
 * types shared by both ends: state encodings, state records, helpers.
 * assumes pcib_regs.svh on the include path.
 */
package pcib_pkg;
	`include "pcib_regs.svh"

	// ------------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PI_IDLE = 2'h0, PI_ADDR = 2'h1, PI_DATA = 2'h3, PI_TURN = 2'h2
	} pcib_ini_t;

	typedef enum logic [2:0] {
		PT_IDLE = 3'h0, PT_CLAIM = 3'h1, PT_DATA = 3'h3,
		PT_TURN = 3'h2, PT_WAIT = 3'h4
	} pcib_tgt_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'h0, HS_ADDR = 3'h1, HS_DATA = 3'h3, HS_TURN = 3'h2,
		HS_TCLM = 3'h4, HS_TDAT = 3'h5, HS_TEND = 3'h7
	} pcib_hst_t;

	// ------------------------------------------------------------------
	// state records, one per end
	// ------------------------------------------------------------------
	typedef struct packed {
		pcib_ini_t   ist;
		pcib_tgt_t   tst;
		logic [2:0]  icnt;
		logic [2:0]  tcnt;
		logic        frame_q;
		logic [31:0] ad;
		logic        ad_oe;
		logic [3:0]  cbe_n;
		logic        cbe_oe;
		logic        frame_n;
		logic        frame_oe;
		logic        irdy_n;
		logic        irdy_oe;
		logic        trdy_n;
		logic        devsel_n;
		logic        tgt_oe;
		logic        par;
		logic        par_oe;
		logic        clkrun_n;
		logic        wr;
		logic [3:0]  be_n;
		logic [31:0] wdata;
		logic        req_rdy;
		logic        rsp_vld;
		logic [31:0] rsp_data;
		logic        rsp_abort;
		logic [31:0] taddr;
		logic        twr;
		logic        tgt_stb;
		logic [3:0]  tbe;
		logic [31:0] twdata;
	} pcib_dev_st_t;

	typedef struct packed {
		pcib_hst_t   st;
		logic [2:0]  cnt;
		logic        frame_q;
		logic [31:0] ad;
		logic        ad_oe;
		logic [3:0]  cbe_n;
		logic        cbe_oe;
		logic        frame_n;
		logic        frame_oe;
		logic        irdy_n;
		logic        irdy_oe;
		logic        trdy_n;
		logic        devsel_n;
		logic        tgt_oe;
		logic        idsel;
		logic        clkrun_n;
		logic        clkrun_oe;
		logic        wr;
		logic [3:0]  be_n;
		logic [31:0] wdata;
		logic        req_rdy;
		logic        rsp_vld;
		logic [31:0] rsp_data;
		logic        rsp_abort;
		logic [31:0] taddr;
		logic        tgt_stb;
		logic [3:0]  tbe;
		logic [31:0] twdata;
	} pcib_host_st_t;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic pcib_is_write(input logic [3:0] cmd);
		return cmd[0];
	endfunction

	function automatic logic pcib_bus_idle(input logic frame_n,
		input logic irdy_n);
		return frame_n & irdy_n;
	endfunction
endpackage

// >>> rtl/pcib_if.sv
/*
 * the shared pci lines between the bridge end and the host end.
 * assumes pull-ups on every line: an undriven line reads high.
 */
`timescale 1ns/1ps
interface pcib_if;
	logic [31:0] dev_ad, host_ad, ad;
	logic        dev_ad_oe, host_ad_oe;
	logic [3:0]  dev_cbe_n, host_cbe_n, cbe_n;
	logic        dev_cbe_oe, host_cbe_oe;
	logic        dev_frame_n, host_frame_n, frame_n;
	logic        dev_frame_oe, host_frame_oe;
	logic        dev_irdy_n, host_irdy_n, irdy_n;
	logic        dev_irdy_oe, host_irdy_oe;
	logic        dev_trdy_n, host_trdy_n, trdy_n;
	logic        dev_devsel_n, host_devsel_n, devsel_n;
	logic        dev_tgt_oe, host_tgt_oe;
	logic        dev_par, par, dev_par_oe;
	logic        dev_clkrun_n, host_clkrun_n, clkrun_n;
	logic        dev_clkrun_oe, host_clkrun_oe;
	logic        idsel;

	// ------------------------------------------------------------------
	// wired resolution with pull-up; a clash reads as the and of drivers
	// ------------------------------------------------------------------
	assign ad = (dev_ad | ~{32{dev_ad_oe}}) & (host_ad | ~{32{host_ad_oe}});
	assign cbe_n = (dev_cbe_n | ~{4{dev_cbe_oe}})
		& (host_cbe_n | ~{4{host_cbe_oe}});
	assign frame_n = (dev_frame_n | ~dev_frame_oe)
		& (host_frame_n | ~host_frame_oe);
	assign irdy_n = (dev_irdy_n | ~dev_irdy_oe)
		& (host_irdy_n | ~host_irdy_oe);
	assign trdy_n = (dev_trdy_n | ~dev_tgt_oe)
		& (host_trdy_n | ~host_tgt_oe);
	assign devsel_n = (dev_devsel_n | ~dev_tgt_oe)
		& (host_devsel_n | ~host_tgt_oe);
	assign par = dev_par | ~dev_par_oe;
	assign clkrun_n = (dev_clkrun_n | ~dev_clkrun_oe)
		& (host_clkrun_n | ~host_clkrun_oe);

	modport dev (
		output dev_ad, dev_ad_oe, dev_cbe_n, dev_cbe_oe, dev_frame_n,
		output dev_frame_oe, dev_irdy_n, dev_irdy_oe, dev_trdy_n,
		output dev_devsel_n, dev_tgt_oe, dev_par, dev_par_oe,
		output dev_clkrun_n, dev_clkrun_oe,
		input  ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, idsel,
		input  clkrun_n
	);
	modport host (
		output host_ad, host_ad_oe, host_cbe_n, host_cbe_oe, host_frame_n,
		output host_frame_oe, host_irdy_n, host_irdy_oe, host_trdy_n,
		output host_devsel_n, host_tgt_oe, host_clkrun_n, host_clkrun_oe,
		output idsel,
		input  ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n, par, clkrun_n
	);
endinterface

// >>> rtl/pcib_host_end.sv
/*
 * host end of the pci link: single-phase initiator plus a simple target
 * for cycles the bridge starts. assumes a grant input that is never
 * given to both ends in the same cycle.
 */
`timescale 1ns/1ps
`include "pcib_regs.svh"
module pcib_host_end
	import pcib_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_GRANT,
	input  wire logic        I_REQ_VALID,
	input  wire logic [31:0] I_REQ_ADDR,
	input  wire logic [3:0]  I_REQ_CMD,
	input  wire logic [3:0]  I_REQ_BE,
	input  wire logic [31:0] I_REQ_WDATA,
	input  wire logic        I_REQ_IDSEL,
	input  wire logic        I_CLKRUN_REQ,
	input  wire logic        I_TGT_EN,
	input  wire logic [31:0] I_TGT_RDATA,
	output logic             O_REQ_READY,
	output logic             O_RSP_VALID,
	output logic [31:0]      O_RSP_DATA,
	output logic             O_RSP_ABORT,
	output logic             O_TGT_STB,
	output logic             O_TGT_WRITE,
	output logic [31:0]      O_TGT_ADDR,
	output logic [3:0]       O_TGT_BE,
	output logic [31:0]      O_TGT_WDATA,
	pcib_if.host             bus
);
	localparam pcib_host_st_t HOST_RST = '{st: HS_IDLE, cnt: `PCIB_CNT_RST,
		frame_q: 1'b1, frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1,
		devsel_n: 1'b1, clkrun_n: 1'b1, cbe_n: 4'hF, be_n: 4'hF,
		default: '0};

	pcib_host_st_t r_reg, r_next;
	logic          start;

	always_comb begin
		r_next = r_reg;
		r_next.frame_q = bus.frame_n;
		r_next.rsp_vld = 1'b0;
		r_next.tgt_stb = 1'b0;
		r_next.req_rdy = 1'b0;
		// clock-run held low only while local logic wants the clock
		r_next.clkrun_n = 1'b0;
		r_next.clkrun_oe = I_CLKRUN_REQ;
		start = I_REQ_VALID && r_reg.req_rdy && I_GRANT
			&& pcib_bus_idle(bus.frame_n, bus.irdy_n);
		case (r_reg.st)
			HS_IDLE: begin
				r_next.tgt_oe = 1'b0;
				r_next.irdy_oe = 1'b0;
				if (!bus.frame_n && r_reg.frame_q && I_TGT_EN) begin
					r_next.st = HS_TCLM;
					r_next.taddr = bus.ad;
					r_next.wr = pcib_is_write(bus.cbe_n);
					r_next.devsel_n = 1'b0;
					r_next.tgt_oe = 1'b1;
				end else if (start) begin
					// address on the first clock, low bits zero
					r_next.st = HS_ADDR;
					r_next.ad = {I_REQ_ADDR[31:2], 2'b00};
					r_next.ad_oe = 1'b1;
					r_next.cbe_n = I_REQ_CMD;
					r_next.cbe_oe = 1'b1;
					r_next.frame_n = 1'b0;
					r_next.frame_oe = 1'b1;
					r_next.irdy_n = 1'b1;
					r_next.irdy_oe = 1'b1;
					r_next.idsel = I_REQ_IDSEL;
					r_next.wr = pcib_is_write(I_REQ_CMD);
					r_next.wdata = I_REQ_WDATA;
					r_next.be_n = ~I_REQ_BE;
					r_next.cnt = `PCIB_CNT_RST;
				end else begin
					r_next.req_rdy = 1'b1;
				end
			end
			HS_ADDR: begin
				// single data phase: frame off marks the last one
				r_next.st = HS_DATA;
				r_next.frame_n = 1'b1;
				r_next.irdy_n = 1'b0;
				r_next.idsel = 1'b0;
				r_next.cbe_n = r_reg.be_n;
				r_next.ad = r_reg.wdata;
				r_next.ad_oe = r_reg.wr;
			end
			HS_DATA: begin
				r_next.cnt = r_reg.cnt + 3'h1;
				if (!bus.irdy_n && !bus.trdy_n) begin
					r_next.st = HS_TURN;
					r_next.rsp_vld = 1'b1;
					r_next.rsp_data = bus.ad;
					r_next.rsp_abort = 1'b0;
				end else if (bus.devsel_n && r_reg.cnt == `PCIB_ABORT_CLKS) begin
					r_next.st = HS_TURN;
					r_next.rsp_vld = 1'b1;
					r_next.rsp_abort = 1'b1;
				end
				if (r_next.st == HS_TURN) begin
					r_next.irdy_n = 1'b1;
					r_next.ad_oe = 1'b0;
					r_next.cbe_oe = 1'b0;
					r_next.frame_oe = 1'b0;
				end
			end
			HS_TURN: begin
				r_next.st = HS_IDLE;
				r_next.irdy_oe = 1'b0;
			end
			HS_TCLM: begin
				r_next.st = HS_TDAT;
				r_next.trdy_n = 1'b0;
				r_next.ad = I_TGT_RDATA;
				r_next.ad_oe = !r_reg.wr;
			end
			HS_TDAT: begin
				if (!bus.irdy_n) begin
					r_next.st = HS_TEND;
					r_next.tgt_stb = 1'b1;
					r_next.tbe = ~bus.cbe_n;
					r_next.twdata = bus.ad;
					r_next.trdy_n = 1'b1;
					r_next.devsel_n = 1'b1;
					r_next.ad_oe = 1'b0;
				end
			end
			HS_TEND: begin
				r_next.st = HS_IDLE;
				r_next.tgt_oe = 1'b0;
			end
			default: r_next = HOST_RST;
		endcase
	end

	// sampled and driven on the rising pci clock only
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			r_reg <= HOST_RST;
		else
			r_reg <= r_next;
	end

	assign O_REQ_READY = r_reg.req_rdy;
	assign O_RSP_VALID = r_reg.rsp_vld;
	assign O_RSP_DATA = r_reg.rsp_data;
	assign O_RSP_ABORT = r_reg.rsp_abort;
	assign O_TGT_STB = r_reg.tgt_stb;
	assign O_TGT_WRITE = r_reg.wr;
	assign O_TGT_ADDR = r_reg.taddr;
	assign O_TGT_BE = r_reg.tbe;
	assign O_TGT_WDATA = r_reg.twdata;
	assign bus.host_ad = r_reg.ad;
	assign bus.host_ad_oe = r_reg.ad_oe;
	assign bus.host_cbe_n = r_reg.cbe_n;
	assign bus.host_cbe_oe = r_reg.cbe_oe;
	assign bus.host_frame_n = r_reg.frame_n;
	assign bus.host_frame_oe = r_reg.frame_oe;
	assign bus.host_irdy_n = r_reg.irdy_n;
	assign bus.host_irdy_oe = r_reg.irdy_oe;
	assign bus.host_trdy_n = r_reg.trdy_n;
	assign bus.host_devsel_n = r_reg.devsel_n;
	assign bus.host_tgt_oe = r_reg.tgt_oe;
	assign bus.idsel = r_reg.idsel;
	assign bus.host_clkrun_n = r_reg.clkrun_n;
	assign bus.host_clkrun_oe = r_reg.clkrun_oe;
endmodule

// >>> rtl/pcib_bridge_end.sv
/*
 * bridge end of the pci link: single-phase initiator and a target with
 * fast and subtractive claim. assumes one pci clock, a grant that is
 * exclusive between the ends, and i_tgt_rdata valid for o_tgt_addr.
 */
// Function
// - first clock address, later clocks data
// - little-endian lanes, ad[7:0] lowest byte
// - initiator drives address, ad[1:0] zero
// - target inputs address, supplies or accepts data
// - c/be: command then active-low byte enables
// - drive c/be only as initiator
// - all lines but clock-run floated in reset, suspend
// - clock-run: any agent may hold clock
// - clock-run low in/after reset, high suspend
// - claim config cycles selected by idsel
// - claim positive decodes, subtractive when enabled
// - devsel answers own cycles, gates subtractive
// - devsel floated until driven as target
// - frame marks start, off at last phase
// - frame driven only as initiator
// - config claim devsel on following clock
// - phase completes on irdy and trdy
// - even parity over 36 bits, one clock later
`timescale 1ns/1ps
`include "pcib_regs.svh"
module pcib_bridge_end
	import pcib_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESETN,
	input  wire logic        I_POS,
	input  wire logic        I_GRANT,
	input  wire logic        I_SUBTR_EN,
	input  wire logic        I_REQ_VALID,
	input  wire logic [31:0] I_REQ_ADDR,
	input  wire logic [3:0]  I_REQ_CMD,
	input  wire logic [3:0]  I_REQ_BE,
	input  wire logic [31:0] I_REQ_WDATA,
	input  wire logic [31:0] I_TGT_RDATA,
	output logic             O_REQ_READY,
	output logic             O_RSP_VALID,
	output logic [31:0]      O_RSP_DATA,
	output logic             O_RSP_ABORT,
	output logic             O_TGT_STB,
	output logic             O_TGT_WRITE,
	output logic [31:0]      O_TGT_ADDR,
	output logic [3:0]       O_TGT_BE,
	output logic [31:0]      O_TGT_WDATA,
	pcib_if.dev              bus
);
	// all drivers off, clock-run low: the state both in and after reset
	localparam pcib_dev_st_t DEV_RST = '{ist: PI_IDLE, tst: PT_IDLE,
		icnt: `PCIB_CNT_RST, tcnt: `PCIB_CNT_RST, frame_q: 1'b1,
		frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1, devsel_n: 1'b1,
		cbe_n: 4'hF, be_n: 4'hF, default: '0};

	pcib_dev_st_t r_reg, r_next;
	logic         start;
	logic         addr_ph;
	logic         cfg_hit;
	logic         pos_hit;
	logic         io_cmd;

	// ------------------------------------------------------------------
	// address decode, looked at only in the address phase
	// ------------------------------------------------------------------
	always_comb begin
		addr_ph = !bus.frame_n && r_reg.frame_q && r_reg.ist == PI_IDLE;
		io_cmd = bus.cbe_n == `PCIB_CMD_IO_RD || bus.cbe_n == `PCIB_CMD_IO_WR;
		cfg_hit = bus.idsel && (bus.cbe_n == `PCIB_CMD_CFG_RD
			|| bus.cbe_n == `PCIB_CMD_CFG_WR);
		pos_hit = io_cmd && (
			(bus.ad & `PCIB_INT_MASK) == `PCIB_INT_BASE ||
			(bus.ad & `PCIB_IDE_MASK) == `PCIB_IDE_BASE ||
			(bus.ad & `PCIB_XIO_MASK) == `PCIB_XIO_BASE);
		start = I_REQ_VALID && r_reg.req_rdy && I_GRANT
			&& r_reg.tst == PT_IDLE
			&& pcib_bus_idle(bus.frame_n, bus.irdy_n);
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.frame_q = bus.frame_n;
		r_next.rsp_vld = 1'b0;
		r_next.tgt_stb = 1'b0;
		r_next.req_rdy = 1'b0;
		// parity covers what the bus showed one clock before
		r_next.par = ^{bus.ad, bus.cbe_n};
		r_next.par_oe = r_reg.ad_oe;
		// clock stays low outside suspend so others see it kept
		r_next.clkrun_n = I_POS;

		case (r_reg.ist)
			PI_IDLE: begin
				r_next.irdy_oe = 1'b0;
				if (start) begin
					r_next.ist = PI_ADDR;
					r_next.ad = {I_REQ_ADDR[31:2], 2'b00};
					r_next.ad_oe = 1'b1;
					r_next.cbe_n = I_REQ_CMD;
					r_next.cbe_oe = 1'b1;
					r_next.frame_n = 1'b0;
					r_next.frame_oe = 1'b1;
					r_next.irdy_n = 1'b1;
					r_next.irdy_oe = 1'b1;
					r_next.wr = pcib_is_write(I_REQ_CMD);
					r_next.wdata = I_REQ_WDATA;
					r_next.be_n = ~I_REQ_BE;
					r_next.icnt = `PCIB_CNT_RST;
				end else if (r_reg.tst == PT_IDLE) begin
					r_next.req_rdy = 1'b1;
				end
			end
			PI_ADDR: begin
				r_next.ist = PI_DATA;
				r_next.frame_n = 1'b1;
				r_next.irdy_n = 1'b0;
				r_next.cbe_n = r_reg.be_n;
				r_next.ad = r_reg.wdata;
				// reads release ad for the target's turnaround
				r_next.ad_oe = r_reg.wr;
			end
			PI_DATA: begin
				r_next.icnt = r_reg.icnt + 3'h1;
				if (!bus.irdy_n && !bus.trdy_n) begin
					r_next.ist = PI_TURN;
					r_next.rsp_vld = 1'b1;
					r_next.rsp_data = bus.ad;
					r_next.rsp_abort = 1'b0;
				end else if (bus.devsel_n
					&& r_reg.icnt == `PCIB_ABORT_CLKS) begin
					// nobody claimed: master abort
					r_next.ist = PI_TURN;
					r_next.rsp_vld = 1'b1;
					r_next.rsp_abort = 1'b1;
				end
				if (r_next.ist == PI_TURN) begin
					r_next.irdy_n = 1'b1;
					r_next.ad_oe = 1'b0;
					r_next.cbe_oe = 1'b0;
					r_next.frame_oe = 1'b0;
				end
			end
			PI_TURN: begin
				// irdy driven high one clock before release
				r_next.ist = PI_IDLE;
				r_next.irdy_oe = 1'b0;
			end
			default: r_next.ist = PI_IDLE;
		endcase

		case (r_reg.tst)
			PT_IDLE: begin
				r_next.tgt_oe = 1'b0;
				if (addr_ph) begin
					// address phase: ad and c/be are inputs
					r_next.taddr = bus.ad;
					r_next.twr = pcib_is_write(bus.cbe_n);
					r_next.tcnt = `PCIB_CNT_RST;
					if (cfg_hit || pos_hit) begin
						r_next.tst = PT_CLAIM;
						r_next.devsel_n = 1'b0;
						r_next.tgt_oe = 1'b1;
					end else if (I_SUBTR_EN && !bus.cbe_n[3]) begin
						r_next.tst = PT_WAIT;
					end
				end
			end
			PT_WAIT: begin
				// subtractive: claim late only if nobody else did
				r_next.tcnt = r_reg.tcnt + 3'h1;
				if (!bus.devsel_n) begin
					r_next.tst = PT_IDLE;
				end else if (r_reg.tcnt == `PCIB_SUB_WAIT) begin
					r_next.tst = PT_CLAIM;
					r_next.devsel_n = 1'b0;
					r_next.tgt_oe = 1'b1;
				end
			end
			PT_CLAIM: begin
				r_next.tst = PT_DATA;
				r_next.trdy_n = 1'b0;
				r_next.ad = I_TGT_RDATA;
				r_next.ad_oe = !r_reg.twr;
			end
			PT_DATA: begin
				if (!bus.irdy_n) begin
					r_next.tst = PT_TURN;
					r_next.tgt_stb = 1'b1;
					r_next.tbe = ~bus.cbe_n;
					r_next.twdata = bus.ad;
					r_next.trdy_n = 1'b1;
					r_next.devsel_n = 1'b1;
					r_next.ad_oe = 1'b0;
				end
			end
			PT_TURN: begin
				r_next.tst = PT_IDLE;
				r_next.tgt_oe = 1'b0;
			end
			default: r_next.tst = PT_IDLE;
		endcase

		// suspend drops every cycle and floats all lines but clock-run, which is driven high
		if (I_POS) begin
			r_next = DEV_RST;
			r_next.frame_q = bus.frame_n;
			r_next.clkrun_n = 1'b1;
		end
	end

	// async reset lands in the all-floated idle record
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			r_reg <= DEV_RST;
		else
			r_reg <= r_next;
	end

	// ------------------------------------------------------------------
	// outputs, all from the state record but the constant clock-run enable
	// ------------------------------------------------------------------
	assign O_REQ_READY = r_reg.req_rdy;
	assign O_RSP_VALID = r_reg.rsp_vld;
	assign O_RSP_DATA = r_reg.rsp_data;
	assign O_RSP_ABORT = r_reg.rsp_abort;
	assign O_TGT_STB = r_reg.tgt_stb;
	assign O_TGT_WRITE = r_reg.twr;
	assign O_TGT_ADDR = r_reg.taddr;
	assign O_TGT_BE = r_reg.tbe;
	assign O_TGT_WDATA = r_reg.twdata;
	assign bus.dev_ad = r_reg.ad;
	assign bus.dev_ad_oe = r_reg.ad_oe;
	assign bus.dev_cbe_n = r_reg.cbe_n;
	assign bus.dev_cbe_oe = r_reg.cbe_oe;
	assign bus.dev_frame_n = r_reg.frame_n;
	assign bus.dev_frame_oe = r_reg.frame_oe;
	assign bus.dev_irdy_n = r_reg.irdy_n;
	assign bus.dev_irdy_oe = r_reg.irdy_oe;
	assign bus.dev_trdy_n = r_reg.trdy_n;
	assign bus.dev_devsel_n = r_reg.devsel_n;
	assign bus.dev_tgt_oe = r_reg.tgt_oe;
	assign bus.dev_par = r_reg.par;
	assign bus.dev_par_oe = r_reg.par_oe;
	assign bus.dev_clkrun_n = r_reg.clkrun_n;
	// clock-run is always driven: low, or high in suspend
	assign bus.dev_clkrun_oe = 1'b1;
endmodule

// >>> verification/pcib_port_checker.sv
/* assertions on the shared pci lines of the two joined ends.
 * assumes an instance beside the interface, fed its own lines. */
`timescale 1ns/1ps
module pcib_port_checker (
	input wire logic        I_CLK,
	input wire logic        I_RESETN,
	input wire logic [31:0] ad,
	input wire logic [3:0]  cbe_n,
	input wire logic        frame_n,
	input wire logic        irdy_n,
	input wire logic        trdy_n,
	input wire logic        devsel_n,
	input wire logic        idsel,
	input wire logic [31:0] dev_ad,
	input wire logic        dev_ad_oe,
	input wire logic        dev_cbe_oe,
	input wire logic        dev_frame_oe,
	input wire logic        dev_tgt_oe,
	input wire logic        dev_par,
	input wire logic        dev_par_oe
);
	// --------------------
	// protocol checks
	// --------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	a_cbe_init_only: assert property (
		dev_cbe_oe |-> !dev_tgt_oe) else $error("c/be driven as target");
	a_frame_init_only: assert property (
		dev_frame_oe |-> !dev_tgt_oe) else $error("frame driven as target");
	a_addr_low_zero: assert property (
		dev_frame_oe && !frame_n |-> dev_ad[1:0] == 2'h0)
		else $error("address low bits not zero");
	a_par_even: assert property (
		dev_par_oe |-> dev_par == ^{$past(ad), $past(cbe_n)})
		else $error("parity wrong");
	a_par_oe_delay: assert property (
		dev_par_oe == $past(dev_ad_oe)) else $error("parity enable late");
	a_cfg_claim_next: assert property (
		$fell(frame_n) && idsel && cbe_n[3:1] == 3'h5
		|=> !devsel_n && dev_tgt_oe) else $error("config not claimed");
	a_phase_done: assert property (
		!irdy_n && !trdy_n |=> irdy_n && trdy_n)
		else $error("phase not ended");
	a_last_phase: assert property (
		!irdy_n |-> frame_n) else $error("frame held in last phase");
	a_tgt_addr_in: assert property (
		!frame_n && !dev_frame_oe |-> !dev_ad_oe)
		else $error("target drove address");
endmodule

// >>> verification/tb_pci_initiator_target_port.sv
/* bench for the two pci ends joined back to back: table and random
 * transfers both ways, decodes, suspend, reset.
 * assumes the rtl package, interface and both ends compiled first. */
`timescale 1ns/1ps
module tb_pci_initiator_target_port;
	import pcib_pkg::*;
	logic             I_CLK = 1'b0;
	logic             I_RESETN = 1'b0;
	logic             pos = 1'b0, sub = 1'b0, idsel = 1'b0;
	logic             ckr = 1'b0, ten = 1'b0;
	logic [1:0]       v = '0, g = '0;
	logic [1:0][3:0]  c = '0, e = '0;
	logic [1:0][31:0] a = '0, w = '0;
	wire [1:0]        rdy, rv, rab, ts, tw;
	wire [1:0][3:0]   tbe;
	wire [1:0][31:0]  rd, ta, twd;
	integer           seed = 85043, mismatches = 0, n_checks = 0, i;
	logic [31:0]      r;
	logic [39:0]      t;
	logic [39:0]      tbl [11] = '{40'h1B00000010, 40'h1A00000014,
		40'h0A00000014, 40'h03000001F3, 40'h020000030F, 40'h02000000FC,
		40'h0300000100, 40'h2300000100, 40'h2680000000, 40'h0780000000,
		40'h02000001F8};
	pcib_if bus_if ();
	wire [5:0] doe = {bus_if.dev_ad_oe, bus_if.dev_cbe_oe,
		bus_if.dev_frame_oe, bus_if.dev_tgt_oe, bus_if.dev_par_oe,
		bus_if.dev_irdy_oe};

	always #20 I_CLK = ~I_CLK;

	// --------------------
	// helpers
	// --------------------
	function automatic logic [31:0] rdf(input logic sd, input logic [31:0] x);
		return sd ? x ^ 32'hA5A50F0F : ~x;
	endfunction

	// bridge claim of a host cycle; subtractive only for cbe[3] low
	function automatic logic claims(input logic [3:0] cm,
		input logic [31:0] x, input logic id, input logic sb);
		return (cm[3:1] == 3'h5 && id) || (sb && !cm[3])
			|| (cm[3:1] == 3'h1 && (x[31:8] == 24'h0
			|| x[31:3] == 29'h3E || x[31:4] == 28'h30));
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex, seen);
		n_checks++;
		if (seen !== ex) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, ex, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tmo();
		mismatches++;
		final_report();
	endtask

	// one transfer started by side s (0 host, 1 bridge)
	task automatic xfer(input logic s, input logic [3:0] cm,
		input logic [31:0] x, wd, input logic [3:0] be, input logic cl);
		int          n;
		logic        seen;
		logic [31:0] aa;
		aa = {x[31:2], 2'h0};
		seen = 1'b0;
		n = 0;
		@(posedge I_CLK);
		g[s] <= 1'b1;
		g[!s] <= 1'b0;
		v[s] <= 1'b1;
		a[s] <= x;
		c[s] <= cm;
		e[s] <= be;
		w[s] <= wd;
		@(negedge I_CLK);
		while (!(rdy[s] === 1'b1 && bus_if.frame_n && bus_if.irdy_n)) begin
			if (++n > 50)
				tmo();
			@(negedge I_CLK);
		end
		@(posedge I_CLK);
		v[s] <= 1'b0;
		n = 0;
		do begin
			@(negedge I_CLK);
			if (!bus_if.frame_n) begin
				chk("addr", aa, bus_if.ad);
				chk("cmd", cm, bus_if.cbe_n);
			end
			if (!bus_if.irdy_n && !bus_if.trdy_n) begin
				chk("data", cm[0] ? wd : rdf(!s, aa), bus_if.ad);
				chk("be", {28'h0, ~be}, bus_if.cbe_n);
			end
			if (ts[!s] === 1'b1) begin
				seen = 1'b1;
				chk("taddr", aa, ta[!s]);
				chk("twr", cm[0], tw[!s]);
				chk("tbe", be, tbe[!s]);
				if (cm[0])
					chk("twdata", wd, twd[!s]);
			end
		end while (rv[s] !== 1'b1 && ++n < 20);
		if (n >= 20)
			tmo();
		chk("abort", !cl, rab[s]);
		chk("claimed", cl, seen);
		if (cl && !cm[0])
			chk("rdata", rdf(!s, aa), rd[s]);
	endtask

	// --------------------
	// ends and checker
	// --------------------
	pcib_bridge_end u_pcib_bridge_end (.I_CLK, .I_RESETN, .I_POS(pos),
		.I_GRANT(g[1]), .I_SUBTR_EN(sub), .I_REQ_VALID(v[1]),
		.I_REQ_ADDR(a[1]), .I_REQ_CMD(c[1]), .I_REQ_BE(e[1]),
		.I_REQ_WDATA(w[1]), .I_TGT_RDATA(rdf(1'b1, ta[1])),
		.O_REQ_READY(rdy[1]), .O_RSP_VALID(rv[1]), .O_RSP_DATA(rd[1]),
		.O_RSP_ABORT(rab[1]), .O_TGT_STB(ts[1]), .O_TGT_WRITE(tw[1]),
		.O_TGT_ADDR(ta[1]), .O_TGT_BE(tbe[1]), .O_TGT_WDATA(twd[1]),
		.bus(bus_if.dev));
	pcib_host_end u_pcib_host_end (.I_CLK, .I_RESETN, .I_GRANT(g[0]),
		.I_REQ_VALID(v[0]), .I_REQ_ADDR(a[0]), .I_REQ_CMD(c[0]),
		.I_REQ_BE(e[0]), .I_REQ_WDATA(w[0]), .I_REQ_IDSEL(idsel),
		.I_CLKRUN_REQ(ckr), .I_TGT_EN(ten), .I_TGT_RDATA(rdf(1'b0, ta[0])),
		.O_REQ_READY(rdy[0]), .O_RSP_VALID(rv[0]), .O_RSP_DATA(rd[0]),
		.O_RSP_ABORT(rab[0]), .O_TGT_STB(ts[0]), .O_TGT_WRITE(tw[0]),
		.O_TGT_ADDR(ta[0]), .O_TGT_BE(tbe[0]), .O_TGT_WDATA(twd[0]),
		.bus(bus_if.host));
	pcib_port_checker u_pcib_port_checker (.I_CLK, .I_RESETN,
		.ad(bus_if.ad), .cbe_n(bus_if.cbe_n), .frame_n(bus_if.frame_n),
		.irdy_n(bus_if.irdy_n), .trdy_n(bus_if.trdy_n),
		.devsel_n(bus_if.devsel_n), .idsel(bus_if.idsel),
		.dev_ad(bus_if.dev_ad), .dev_ad_oe(bus_if.dev_ad_oe),
		.dev_cbe_oe(bus_if.dev_cbe_oe), .dev_frame_oe(bus_if.dev_frame_oe),
		.dev_tgt_oe(bus_if.dev_tgt_oe), .dev_par(bus_if.dev_par),
		.dev_par_oe(bus_if.dev_par_oe));

	initial begin
		repeat (6) @(posedge I_CLK);
		chk("rst oe", 6'h0, doe);
		chk("rst clkrun", 1'b0, bus_if.dev_clkrun_n);
		I_RESETN <= 1'b1;
		repeat (2) @(negedge I_CLK);
		chk("clkrun after", 1'b0, bus_if.dev_clkrun_n);
		// table corners first, then random host-started cycles
		for (i = 0; i < 27; i++) begin
			r = $random(seed);
			t = (i < 11) ? tbl[i] : {2'h0, r[17:16], r[4:3] == 2'h0 ?
				{3'h5, r[0]} : {1'b0, r[1], 1'b1, r[0]},
				r[5] ? $random(seed) : {22'h0, r[15:6]}};
			@(posedge I_CLK);
			{sub, idsel} <= t[37:36];
			xfer(1'b0, t[35:32], t[31:0], $random(seed), r[23:20],
				claims(t[35:32], t[31:0], t[36], t[37]));
		end
		for (i = 0; i < 10; i++) begin
			r = $random(seed);
			@(posedge I_CLK);
			ten <= r[8];
			xfer(1'b1, {1'b0, r[1], 1'b1, r[0]}, $random(seed),
				$random(seed), r[7:4], r[8]);
		end
		@(posedge I_CLK);
		ckr <= 1'b1;
		pos <= 1'b1;
		repeat (2) @(negedge I_CLK);
		chk("pos oe", 6'h0, doe);
		chk("pos clkrun", 1'b1, bus_if.dev_clkrun_n);
		chk("clkrun held", 1'b0, bus_if.clkrun_n);
		chk("pos ready", 1'b0, rdy[1]);
		@(posedge I_CLK);
		pos <= 1'b0;
		ckr <= 1'b0;
		I_RESETN <= 1'b0;
		@(negedge I_CLK);
		chk("rerst oe", 6'h0, doe);
		@(posedge I_CLK);
		I_RESETN <= 1'b1;
		repeat (2) @(posedge I_CLK);
		sub <= 1'b1;
		xfer(1'b0, 4'h2, 32'h00000310, 32'h0, 4'hF, 1'b1);
		final_report();
	end
endmodule
